// ==== logic/lkt_time_keeper.sv ====
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// local time keeper: calendar, offset, seasonal changeover, sync status
// assumes a 200 MHz quartz-derived clock and a plain register port
//
// How it works
// - time and date fields within documented ranges
// - offset fixed to standard time, season adds hour
// - offset carries sign, hours and minutes
// - master/slave mode takes offset from string
// - rules hold hour, weekday, week, month
// - two rules yield changeover days each year
// - new rules take effect at next minute
// - all-zero rules mean permanent standard time
// - satellite and quartz modes use internal rules
// - other modes follow source unless internal chosen, or fallback set without reception
// - reception set after lock-on delay elapses
// - delayed status driven onto the system bus
// - reception held through loss until holdover ends
// - timekeeping continues from quartz when source fails
// - delayed status governs reception output, status register readback and fallback season choice only
// - two-bit source setting selects changeover origin
module lkt_time_keeper
  import lkt_pkg::*;
#(
  parameter int SEC_COUNT = SEC_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data,
  // synchronization source pins
  input wire logic sync_present,
  input wire logic ext_summer,
  input wire logic [11:0] ext_offset,
  // system bus status
  output logic reception_status,
  output logic summer_time,
  output logic second_pulse
);
  // calendar state, stored in standard time
  logic [5:0] sec_reg;
  logic [5:0] min_reg;
  logic [4:0] hour_reg;
  logic [4:0] day_reg;
  logic [3:0] month_reg;
  logic [6:0] year_reg;
  logic [27:0] tick_reg;
  logic sec_tick;
  logic min_tick;
  logic hour_tick;
  logic day_tick;
  logic month_tick;
  // settings
  logic [11:0] offset_reg;
  logic [17:0] rule_on_reg;
  logic [17:0] rule_off_reg;
  logic [17:0] act_on_reg;
  logic [17:0] act_off_reg;
  logic [7:0] on_delay_reg;
  logic [7:0] off_delay_reg;
  logic [3:0] mode_reg;
  logic [1:0] src_reg;
  // pin synchronizers
  logic [13:0] pin_meta_reg;
  logic [13:0] pin_sync_reg;
  logic present_s;
  logic ext_summer_s;
  logic [11:0] ext_offset_s;
  // derived
  logic [4:0] on_day;
  logic [4:0] off_day;
  logic use_internal;
  logic rules_zero;
  logic int_summer;
  logic summer_next;
  logic [11:0] offset_eff;
  logic status_int;
  logic [31:0] rd_next;
  logic time_wr;
  logic date_wr;

  // rule word: [17:13] hour, [10:8] weekday, [6:4] week, [3:0] month
  function automatic logic [13:0] rule_key(input logic [17:0] r,
                                           input logic [4:0] d);
    rule_key = {r[3:0], d, r[17:13]};
  endfunction : rule_key

  function automatic logic [17:0] rule_pack(input logic [31:0] w);
    rule_pack = {w[20:16], 2'h0, w[10:8], 1'b0, w[6:4], w[3:0]};
  endfunction : rule_pack

  assign time_wr = wr_strobe && addr == ADDR_TIME;
  assign date_wr = wr_strobe && addr == ADDR_DATE;

  // source pins are outside this domain
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_meta_reg <= 14'h0000;
      pin_sync_reg <= 14'h0000;
    end else begin
      pin_meta_reg <= {sync_present, ext_summer, ext_offset};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  // the offset word is quasi-static; a torn word lasts one cycle at most
  assign present_s = pin_sync_reg[13];
  assign ext_summer_s = pin_sync_reg[12];
  assign ext_offset_s = pin_sync_reg[11:0];

  // second timebase from the quartz clock, independent of the source
  always_ff @(posedge clock) begin
    if (!rstn || time_wr) begin
      tick_reg <= 28'h0000000;
    end else if (sec_tick) begin
      tick_reg <= 28'h0000000;
    end else begin
      tick_reg <= tick_reg + 28'h0000001;
    end
  end
  assign sec_tick = tick_reg == 28'(SEC_COUNT - 1);
  assign min_tick = sec_tick && sec_reg == SEC_LAST;
  assign hour_tick = min_tick && min_reg == SEC_LAST;
  assign day_tick = hour_tick && hour_reg == HOUR_LAST;
  assign month_tick = day_tick &&
                      day_reg == days_in_month(year_reg, month_reg);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sec_reg <= 6'h00;
      min_reg <= 6'h00;
      hour_reg <= 5'h00;
    end else if (time_wr) begin
      sec_reg <= wr_data[5:0];
      min_reg <= wr_data[13:8];
      hour_reg <= wr_data[20:16];
    end else if (sec_tick) begin
      sec_reg <= min_tick ? 6'h00 : sec_reg + 6'h01;
      if (min_tick) begin
        min_reg <= hour_tick ? 6'h00 : min_reg + 6'h01;
      end
      if (hour_tick) begin
        hour_reg <= day_tick ? 5'h00 : hour_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      day_reg <= 5'h01;
      month_reg <= 4'h1;
      year_reg <= 7'h00;
    end else if (date_wr) begin
      day_reg <= wr_data[4:0];
      month_reg <= wr_data[11:8];
      year_reg <= 7'(wr_data[27:16] - YEAR_BASE);
    end else if (day_tick) begin
      day_reg <= month_tick ? 5'h01 : day_reg + 5'h01;
      if (month_tick) begin
        month_reg <= (month_reg == MONTH_LAST) ? 4'h1 : month_reg + 4'h1;
        if (month_reg == MONTH_LAST) begin
          year_reg <= (year_reg == YEAR_LAST) ? 7'h00 : year_reg + 7'h01;
        end
      end
    end
  end

  // settings written by the operator
  always_ff @(posedge clock) begin
    if (!rstn) begin
      offset_reg <= 12'h000;
      on_delay_reg <= 8'h00;
      off_delay_reg <= OFF_DELAY_MIN;
      mode_reg <= quartz_only_mode;
      src_reg <= SRC_EXT_ONLY;
    end else if (wr_strobe) begin
      if (addr == ADDR_OFFSET) begin
        offset_reg <= {wr_data[15], wr_data[12:8], wr_data[5:0]};
      end else if (addr == ADDR_DELAY) begin
        on_delay_reg <= wr_data[15:8];
        off_delay_reg <= wr_data[7:0];
      end else if (addr == ADDR_CTRL) begin
        mode_reg <= wr_data[3:0];
        src_reg <= wr_data[6:5];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rule_on_reg <= 18'h00000;
      rule_off_reg <= 18'h00000;
    end else if (wr_strobe && addr == ADDR_RULE_ON) begin
      rule_on_reg <= rule_pack(wr_data);
    end else if (wr_strobe && addr == ADDR_RULE_OFF) begin
      rule_off_reg <= rule_pack(wr_data);
    end
  end

  // rules become active only on a minute rollover, together with the
  // recomputed days, so comparisons never mix old and new values
  always_ff @(posedge clock) begin
    if (!rstn) begin
      act_on_reg <= 18'h00000;
      act_off_reg <= 18'h00000;
    end else if (min_tick) begin
      act_on_reg <= rule_on_reg;
      act_off_reg <= rule_off_reg;
    end
  end

  lkt_change_date u_on_date (
    .clock(clock),
    .rstn(rstn),
    .load(min_tick),
    .year(year_reg),
    .rule_dow(rule_on_reg[10:8]),
    .rule_week(rule_on_reg[6:4]),
    .rule_month(rule_on_reg[3:0]),
    .day_reg(on_day)
  );

  lkt_change_date u_off_date (
    .clock(clock),
    .rstn(rstn),
    .load(min_tick),
    .year(year_reg),
    .rule_dow(rule_off_reg[10:8]),
    .rule_week(rule_off_reg[6:4]),
    .rule_month(rule_off_reg[3:0]),
    .day_reg(off_day)
  );

  // internal season from standard time; southern rules wrap the year
  always_comb begin
    rules_zero = act_on_reg == 18'h00000 && act_off_reg == 18'h00000;
    if (rules_zero) begin
      int_summer = 1'b0;
    end else if (rule_key(act_on_reg, on_day) <
                 rule_key(act_off_reg, off_day)) begin
      int_summer = rule_key({hour_reg, 13'h0000 | 13'(month_reg)},
                            day_reg) >= rule_key(act_on_reg, on_day) &&
                   rule_key({hour_reg, 13'h0000 | 13'(month_reg)},
                            day_reg) < rule_key(act_off_reg, off_day);
    end else begin
      int_summer = rule_key({hour_reg, 13'h0000 | 13'(month_reg)},
                            day_reg) >= rule_key(act_on_reg, on_day) ||
                   rule_key({hour_reg, 13'h0000 | 13'(month_reg)},
                            day_reg) < rule_key(act_off_reg, off_day);
    end
  end

  always_comb begin
    if (mode_reg == satellite_receiver_mode ||
        mode_reg == quartz_only_mode) begin
      use_internal = 1'b1;
    end else if (src_reg[SRC_INT_BIT]) begin
      use_internal = 1'b1;
    end else if (src_reg == SRC_EXT_FALLBACK) begin
      use_internal = !status_int;
    end else begin
      use_internal = 1'b0;
    end
    summer_next = use_internal ? int_summer : ext_summer_s;
    offset_eff = (mode_reg == master_slave_mode) ? ext_offset_s
                                                 : offset_reg;
  end

  lkt_sync_delay u_sync_delay (
    .clock(clock),
    .rstn(rstn),
    .minute_tick(min_tick),
    .present(present_s),
    .on_delay(on_delay_reg),
    .off_delay(off_delay_reg),
    .status_reg(status_int)
  );

  // bus outputs; season is an added hour, the stored offset never moves
  always_ff @(posedge clock) begin
    if (!rstn) begin
      reception_status <= 1'b0;
      summer_time <= 1'b0;
      second_pulse <= 1'b0;
    end else begin
      reception_status <= status_int;
      summer_time <= summer_next;
      second_pulse <= sec_tick;
    end
  end

  // read mux
  always_comb begin
    rd_next = 32'h00000000;
    if (addr == ADDR_TIME) begin
      rd_next = {11'h000, hour_reg, 2'h0, min_reg, 2'h0, sec_reg};
    end else if (addr == ADDR_DATE) begin
      rd_next = {4'h0, YEAR_BASE + 12'(year_reg), 4'h0, month_reg,
                 3'h0, day_reg};
    end else if (addr == ADDR_OFFSET) begin
      rd_next = {16'h0000, offset_eff[11], 2'h0, offset_eff[10:6],
                 2'h0, offset_eff[5:0]};
    end else if (addr == ADDR_RULE_ON) begin
      rd_next = {11'h000, rule_on_reg[17:13], 5'h00, rule_on_reg[10:8],
                 1'b0, rule_on_reg[6:4], rule_on_reg[3:0]};
    end else if (addr == ADDR_RULE_OFF) begin
      rd_next = {11'h000, rule_off_reg[17:13], 5'h00, rule_off_reg[10:8],
                 1'b0, rule_off_reg[6:4], rule_off_reg[3:0]};
    end else if (addr == ADDR_DELAY) begin
      rd_next = {16'h0000, on_delay_reg, off_delay_reg};
    end else if (addr == ADDR_CTRL) begin
      rd_next = {25'h0000000, src_reg, 1'b0, mode_reg};
    end else if (addr == ADDR_STATUS) begin
      rd_next = {28'h0000000, use_internal, present_s, summer_next,
                 status_int};
    end else if (addr == ADDR_DATES) begin
      rd_next = {4'h0, act_on_reg[3:0], 3'h0, on_day,
                 4'h0, act_off_reg[3:0], 3'h0, off_day};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_data <= 32'h00000000;
    end else if (rd_strobe) begin
      rd_data <= rd_next;
    end else begin
      rd_data <= 32'h00000000;
    end
  end
endmodule : lkt_time_keeper

// ==== common/lkt_pkg.sv ====
// constants, register map and calendar helpers for the local time keeper
// assumes a single 200 MHz clock domain and a year field stored as 0..99
package lkt_pkg;
  localparam int CLOCK_HZ = 200_000_000;
  localparam int SEC_PER_S = 1;
  localparam int SEC_CYCLES = CLOCK_HZ * SEC_PER_S;
  localparam logic [11:0] YEAR_BASE = 12'h7D0;
  localparam logic [6:0] YEAR_LAST = 7'h63;
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [3:0] MONTH_LAST = 4'hC;
  localparam logic [7:0] OFF_DELAY_MIN = 8'h02;
  // register indices on the plain port
  localparam logic [3:0] ADDR_TIME = 4'h0;
  localparam logic [3:0] ADDR_DATE = 4'h1;
  localparam logic [3:0] ADDR_OFFSET = 4'h2;
  localparam logic [3:0] ADDR_RULE_ON = 4'h3;
  localparam logic [3:0] ADDR_RULE_OFF = 4'h4;
  localparam logic [3:0] ADDR_DELAY = 4'h5;
  localparam logic [3:0] ADDR_CTRL = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_DATES = 4'h8;
  // synchronization modes
  typedef enum logic [3:0] {
    quartz_only_mode = 4'h0,
    pulse_mode = 4'h2,
    master_slave_mode = 4'h4,
    satellite_receiver_mode = 4'h5
  } lkt_mode_t;
  // changeover source field
  localparam logic [1:0] SRC_EXT_ONLY = 2'h0;
  localparam logic [1:0] SRC_EXT_FALLBACK = 2'h2;
  localparam int SRC_INT_BIT = 0;
  // days from 1 Jan 2000 (a Saturday) to weekday index, Monday = 0
  localparam logic [2:0] DOW_BASE = 3'h5;

  function automatic logic [4:0] days_in_month(input logic [6:0] yr,
                                               input logic [3:0] mon);
    case (mon)
      4'h2: days_in_month = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: days_in_month = 5'h1E;
      default: days_in_month = 5'h1F;
    endcase
  endfunction : days_in_month

  // weekday of the first of a month, 0 = Monday .. 6 = Sunday
  function automatic logic [2:0] dow_first(input logic [6:0] yr,
                                           input logic [3:0] mon);
    logic [15:0] days;
    logic [8:0] cum;
    days = 16'h0;
    case (mon)
      4'h1: cum = 9'h000;
      4'h2: cum = 9'h01F;
      4'h3: cum = 9'h03B;
      4'h4: cum = 9'h05A;
      4'h5: cum = 9'h078;
      4'h6: cum = 9'h097;
      4'h7: cum = 9'h0B5;
      4'h8: cum = 9'h0D4;
      4'h9: cum = 9'h0F3;
      4'hA: cum = 9'h111;
      4'hB: cum = 9'h130;
      default: cum = 9'h14E;
    endcase
    days = 16'(yr) * 16'h016D + 16'((yr + 7'h03) >> 2) + 16'(cum);
    if (yr[1:0] == 2'h0 && mon > 4'h2) begin
      days = days + 16'h0001;
    end
    dow_first = 3'((days + 16'(DOW_BASE)) % 16'h0007);
  endfunction : dow_first
endpackage : lkt_pkg

// ==== logic/lkt_change_date.sv ====
`timescale 1ns/1ps
// turns one changeover rule into its day of month in the current year
// assumes load is a one-cycle pulse from the same clock
module lkt_change_date
  import lkt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // request
  input wire logic load,
  input wire logic [6:0] year,
  input wire logic [2:0] rule_dow,
  input wire logic [2:0] rule_week,
  input wire logic [3:0] rule_month,
  // result
  output logic [4:0] day_reg
);
  logic [2:0] first_dow;
  logic [4:0] first_day;
  logic [4:0] month_len;
  logic [4:0] day_next;

  always_comb begin
    first_dow = dow_first(year, rule_month);
    month_len = days_in_month(year, rule_month);
    // rule weekday is 1..7, internal weekday index 0..6
    first_day = 5'h01 + 5'((3'(rule_dow - 3'h1) + 4'h7 - 4'(first_dow))
                            % 4'h7);
    if (rule_week == 3'h5) begin
      // compare at six bits: a fifth week past day 31 would wrap at five
      day_next = (6'(first_day) + 6'h1C <= 6'(month_len)) ?
                 first_day + 5'h1C : first_day + 5'h15;
    end else begin
      day_next = first_day + 5'(7 * (rule_week - 3'h1));
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      day_reg <= 5'h00;
    end else if (load) begin
      day_reg <= day_next;
    end
  end
endmodule : lkt_change_date

// ==== logic/lkt_sync_delay.sv ====
`timescale 1ns/1ps
// delays the reception status on acquiring and on losing synchronization
// assumes present is already synchronized and minute_tick is one cycle
module lkt_sync_delay
  import lkt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // timing
  input wire logic minute_tick,
  input wire logic present,
  input wire logic [7:0] on_delay,
  input wire logic [7:0] off_delay,
  // result
  output logic status_reg
);
  logic present_q_reg;
  logic [7:0] count_reg;
  logic [7:0] off_eff;

  // holdover below its floor would drop status on a single glitch
  assign off_eff = (off_delay < OFF_DELAY_MIN) ? OFF_DELAY_MIN : off_delay;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      present_q_reg <= 1'b0;
    end else begin
      present_q_reg <= present;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_reg <= 8'h00;
    end else if (present != present_q_reg) begin
      count_reg <= 8'h00;
    end else if (minute_tick && count_reg != 8'hFF) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      status_reg <= 1'b0;
    end else if (present != present_q_reg) begin
      // the count is stale in the cycle of a change; wait for its restart
      status_reg <= status_reg;
    end else if (present && !status_reg && count_reg >= on_delay) begin
      status_reg <= 1'b1;
    end else if (!present && status_reg && count_reg >= off_eff) begin
      status_reg <= 1'b0;
    end
  end
endmodule : lkt_sync_delay

// ==== dv/lkt_src_model.sv ====
// behavioural model of the synchronization source driving the keeper
// assumes bench commands change just after a rising edge of clock
`timescale 1ns/1ps
module lkt_src_model (
  // clock
  input wire logic clock,
  // commands from the bench
  input wire logic go,
  input wire logic [11:0] offset_cmd,
  // source pins
  output logic sync_present,
  output logic ext_summer,
  output logic [11:0] ext_offset
);
  initial begin
    sync_present = 1'b0;
    ext_summer = 1'b0;
    ext_offset = 12'hFFF;
  end
  always @(posedge clock) begin
    sync_present <= go;
    // this source never signals summer time, so any summer hour is internal
    ext_summer <= 1'b0;
    // string content is refreshed only while delivering, held otherwise
    if (go) begin
      ext_offset <= offset_cmd;
    end
  end
endmodule : lkt_src_model

// ==== dv/lkt_chk.sv ====
// port assertions for the local time keeper
// assumes binding onto lkt_time_keeper with its own SEC_COUNT
`timescale 1ns/1ps
module lkt_chk
  import lkt_pkg::*;
#(
  parameter int SEC_COUNT = SEC_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [31:0] rd_data,
  // source and bus status
  input wire logic sync_present,
  input wire logic [11:0] ext_offset,
  input wire logic reception_status,
  input wire logic second_pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [31:0] gap_reg;
  logic gap_ok_reg;
  logic [15:0] dly_reg;
  logic [3:0] mode_reg;
  always_ff @(posedge clock) begin
    gap_reg <= (!rstn || second_pulse) ? 32'h0 : gap_reg + 32'h1;
  end
  // a time write restarts the sub-second count, so skip that interval
  always_ff @(posedge clock) begin
    if (!rstn || (wr_strobe && addr == ADDR_TIME)) begin
      gap_ok_reg <= 1'b0;
    end else if (second_pulse) begin
      gap_ok_reg <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dly_reg <= 16'h0002;
      mode_reg <= 4'h0;
    end else if (wr_strobe && addr == ADDR_DELAY) begin
      dly_reg <= wr_data[15:0];
    end else if (wr_strobe && addr == ADDR_CTRL) begin
      mode_reg <= wr_data[3:0];
    end
  end
  a_rd_idle_zero: assert property (!$past(rd_strobe) |-> rd_data == 32'h0)
    else $error("read data not zero outside answer");
  a_unmapped_zero: assert property ($past(rd_strobe) &&
    $past(addr) > ADDR_DATES |-> rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_time_range: assert property (
    $past(rd_strobe) && $past(addr) == ADDR_TIME |->
    rd_data[20:16] <= HOUR_LAST && rd_data[13:8] <= SEC_LAST &&
    rd_data[5:0] <= SEC_LAST) else $error("time field out of range");
  a_date_range: assert property (
    $past(rd_strobe) && $past(addr) == ADDR_DATE |->
    rd_data[27:16] >= YEAR_BASE && rd_data[27:16] <= YEAR_BASE + 12'h063
    && rd_data[11:8] >= 4'h1 && rd_data[11:8] <= MONTH_LAST &&
    rd_data[4:0] != 5'h00) else $error("date field out of range");
  a_delay_read: assert property (
    $past(rd_strobe) && $past(addr) == ADDR_DELAY |->
    rd_data[15:0] == $past(dly_reg)) else $error("delay readback wrong");
  a_offset_string: assert property (
    $past(rd_strobe) && $past(addr) == ADDR_OFFSET &&
    $past(mode_reg) == master_slave_mode |-> rd_data[15:0] ==
    {ext_offset[11], 2'h0, ext_offset[10:6], 2'h0, ext_offset[5:0]})
    else $error("offset not taken from string");
  a_pulse_single: assert property (second_pulse |=> !second_pulse)
    else $error("second pulse longer than one cycle");
  a_pulse_period: assert property (
    second_pulse && gap_ok_reg |-> gap_reg == 32'(SEC_COUNT - 1))
    else $error("second pulse spacing wrong");
  a_lock_needs_sync: assert property (
    $rose(reception_status) |-> $past(sync_present, 4))
    else $error("reception set without sync");
  a_drop_needs_loss: assert property (
    $fell(reception_status) |-> !$past(sync_present, 4))
    else $error("reception dropped while sync present");
endmodule : lkt_chk

bind lkt_time_keeper lkt_chk #(.SEC_COUNT(SEC_COUNT)) u_chk (
  .clock(clock), .rstn(rstn), .addr(addr), .wr_data(wr_data),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
  .sync_present(sync_present), .ext_offset(ext_offset),
  .reception_status(reception_status), .second_pulse(second_pulse));

// ==== dv/test_local_time_keeper_with_sync_status.sv ====
// self-checking bench for the local time keeper
// assumes source model and checker are compiled before this file
`timescale 1ns/1ps
module test_local_time_keeper_with_sync_status
  import lkt_pkg::*;
;
  localparam int SEC_N = 20;
  localparam int LIMIT = 30000;
  logic clock = 1'b0, rstn = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
  logic go = 1'b0, rd_seen = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0, r = 32'h00015479, e_v, m_v;
  logic [11:0] offset_cmd = 12'h000, off_q, ext_offset;
  logic [31:0] rd_data;
  logic sync_present, ext_summer, reception_status, summer_time;
  logic second_pulse;
  logic [31:0] exp_q[$], msk_q[$];
  int n_fail = 0, check_count = 0, cyc = 0;
  lkt_time_keeper #(.SEC_COUNT(SEC_N)) DUT (.clock(clock), .rstn(rstn),
    .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .sync_present(sync_present),
    .ext_summer(ext_summer), .ext_offset(ext_offset),
    .reception_status(reception_status), .summer_time(summer_time),
    .second_pulse(second_pulse));
  lkt_src_model u_src (.clock(clock), .go(go), .offset_cmd(offset_cmd),
    .sync_present(sync_present), .ext_summer(ext_summer),
    .ext_offset(ext_offset));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] offs(input logic [11:0] o);
    offs = {16'h0, o[11], 2'h0, o[10:6], 2'h0, o[5:0]};
  endfunction : offs
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // the extra edge keeps a strobe from being assigned twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    @(posedge clock);
  endtask : rd
  task automatic wait_pulse(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(posedge clock);
      while (second_pulse !== 1'b1 && k < 200) begin
        @(posedge clock);
        k++;
      end
    end
  endtask : wait_pulse
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) rd_seen <= rd_strobe;
  // answers stand only in the cycle after the strobe, so sample mid-cycle
  always @(negedge clock) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      chk((rd_data & m_v) === e_v, "read data");
    end
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      $display("wrong value at %0t: run timed out", $time);
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(ADDR_TIME, 32'h0, 32'h001F3F3F);
    rd(ADDR_DATE, 32'h07D00101, 32'h0FFF0F1F);
    rd(ADDR_DELAY, 32'h0002, 32'hFFFF);
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    wr(ADDR_TIME, 32'h00173B32);
    wr(ADDR_DATE, 32'h07D3021C);
    wait_pulse(10);
    rd(ADDR_TIME, 32'h0, 32'h001F3F3F);
    rd(ADDR_DATE, 32'h07D30301, 32'h0FFF0F1F);
    done("calendar");
    r = lfsr(r);
    off_q = {r[0], 1'b0, r[4:1], 1'b0, r[9:5]};
    wr(ADDR_OFFSET, offs(off_q));
    rd(ADDR_OFFSET, offs(off_q), 32'h9F3F);
    wr(ADDR_RULE_ON, 32'h00020753);
    wr(ADDR_RULE_OFF, 32'h0003075A);
    wait_pulse(61);
    rd(ADDR_DATES, 32'h031E0A1A, 32'h0F1F0F1F);
    chk(summer_time === 1'b0, "summer too early");
    wr(ADDR_DATE, 32'h07D3031E);
    wr(ADDR_TIME, 32'h00013B3A);
    wait_pulse(1);
    chk(summer_time === 1'b0, "summer before hour");
    wait_pulse(2);
    repeat (5) @(posedge clock);
    chk(summer_time === 1'b1, "summer at hour");
    rd(ADDR_OFFSET, offs(off_q), 32'h9F3F);
    wr(ADDR_CTRL, 32'h02);
    wait_pulse(61);
    chk(summer_time === 1'b0, "summer from source");
    wr(ADDR_CTRL, 32'h05);
    repeat (5) @(posedge clock);
    chk(summer_time === 1'b1, "satellite uses rules");
    wr(ADDR_CTRL, 32'h42);
    wait_pulse(61);
    chk(summer_time === 1'b1, "fallback to rules");
    wr(ADDR_CTRL, 32'h22);
    wr(ADDR_RULE_ON, 32'h0);
    wr(ADDR_RULE_OFF, 32'h0);
    wait_pulse(61);
    chk(summer_time === 1'b0, "zero rules");
    done("season");
    r = lfsr(r);
    wr(ADDR_DELAY, 32'h0A02);
    offset_cmd <= {r[0], 1'b0, r[4:1], 1'b0, r[9:5]};
    go <= 1'b1;
    wr(ADDR_CTRL, 32'h04);
    repeat (8) @(posedge clock);
    rd(ADDR_OFFSET, offs(offset_cmd), 32'h9F3F);
    go <= 1'b0;
    repeat (10) @(posedge clock);
    done("offset");
    wr(ADDR_TIME, 32'h000A0000);
    go <= 1'b1;
    wait_pulse(599);
    chk(reception_status === 1'b0, "lock too early");
    wait_pulse(2);
    repeat (10) @(posedge clock);
    chk(reception_status === 1'b1, "lock");
    rd(ADDR_STATUS, 32'h5, 32'hF);
    go <= 1'b0;
    wait_pulse(89);
    chk(reception_status === 1'b1, "holdover");
    wait_pulse(32);
    repeat (10) @(posedge clock);
    chk(reception_status === 1'b0, "released");
    done("status");
    final_report();
  end
endmodule : test_local_time_keeper_with_sync_status
